//--- hdl/pmc_power_mode_controller.sv
// Global power mode sequencer: modes, wakeups, regulators and clocks
`timescale 1ns/1ps
module pmc_power_mode_controller
#(
   parameter int HIB_WAKE_CYC = pmc_pkg::HIB_WAKE_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   // Firmware mode request
   input wire pmc_pkg::pmc_mode_t mode_req,
   input wire logic mode_req_valid,
   // Firmware templates and regulator control
   input wire logic [pmc_pkg::SUBSYS_N-1:0] tmpl_active,
   input wire logic [pmc_pkg::SUBSYS_N-1:0] tmpl_alt,
   input wire logic core_reg_off,
   // Wakeup sources
   input wire logic irq_wake,
   input wire logic pin_wake,
   input wire logic external_reset_pin,
   input wire logic watchdog_reset_source,
   input wire logic precision_supply_reset,
   // Status and power controls
   output pmc_pkg::pmc_mode_t mode,
   output logic wake_busy,
   output logic cpu_force,
   output logic [pmc_pkg::SUBSYS_N-1:0] subsys_clk_en,
   output logic [pmc_pkg::SUBSYS_N-1:0] subsys_bias_dis,
   output logic sys_clk_en,
   output logic lowspeed_osc_en,
   output logic dig_reg_en,
   output logic ana_reg_en,
   output logic reg_buzz,
   output logic hib_reg_en,
   output logic state_retain
);

   typedef struct packed {
      pmc_pkg::pmc_state_t st;
      pmc_pkg::pmc_mode_t mode;
      logic cpu_force;
      logic sys_clk_en;
      logic lowspeed_osc_en;
      logic dig_reg_en;
      logic ana_reg_en;
      logic reg_buzz;
      logic hib_reg_en;
      logic state_retain;
   } pmc_ctl_t;

   pmc_ctl_t r;
   pmc_ctl_t next_r;

   logic reset_evt;
   logic wake_any;
   logic wake_hib;
   logic tmr_start;
   logic [pmc_pkg::TMR_W-1:0] tmr_load;
   logic tmr_busy;
   logic tmr_expire;
   logic run_mode;
   logic [pmc_pkg::SUBSYS_N-1:0] tmpl_sel;

   localparam logic [pmc_pkg::TMR_W-1:0] SLEEP_LOAD =
      pmc_pkg::TMR_W'(pmc_pkg::SLEEP_WAKE_CYC);
   localparam logic [pmc_pkg::TMR_W-1:0] HIB_LOAD =
      pmc_pkg::TMR_W'(HIB_WAKE_CYC);

   // True for the two modes in which code runs
   function automatic logic is_run(input pmc_pkg::pmc_state_t s);
      case (s)
         pmc_pkg::ST_ACTIVE,
         pmc_pkg::ST_ALT_ACTIVE:
         begin
            is_run = 1'b1;
         end
         default:
         begin
            is_run = 1'b0;
         end
      endcase
   endfunction : is_run

   // Visible mode for each internal state
   function automatic pmc_pkg::pmc_mode_t mode_of(
      input pmc_pkg::pmc_state_t s);
      case (s)
         pmc_pkg::ST_ACTIVE:
         begin
            mode_of = pmc_pkg::MODE_ACTIVE;
         end
         pmc_pkg::ST_ALT_ACTIVE:
         begin
            mode_of = pmc_pkg::MODE_ALT_ACTIVE;
         end
         pmc_pkg::ST_SLEEP:
         begin
            mode_of = pmc_pkg::MODE_SLEEP;
         end
         pmc_pkg::ST_WAKE_SLEEP:
         begin
            mode_of = pmc_pkg::MODE_SLEEP;
         end
         pmc_pkg::ST_HIBERNATE:
         begin
            mode_of = pmc_pkg::MODE_HIBERNATE;
         end
         pmc_pkg::ST_WAKE_HIB:
         begin
            mode_of = pmc_pkg::MODE_HIBERNATE;
         end
         default:
         begin
            mode_of = pmc_pkg::MODE_ACTIVE;
         end
      endcase
   endfunction : mode_of

   // Any wakeup lands in active mode with the CPU forced on
   function automatic pmc_ctl_t woken(input pmc_ctl_t c);
      woken = c;
      woken.st = pmc_pkg::ST_ACTIVE;
      woken.cpu_force = 1'b1;
   endfunction : woken

   // Settle count for the wake state being entered
   function automatic logic [pmc_pkg::TMR_W-1:0] settle_load(
      input pmc_pkg::pmc_state_t s);
      case (s)
         pmc_pkg::ST_WAKE_HIB:
         begin
            settle_load = HIB_LOAD;
         end
         default:
         begin
            settle_load = SLEEP_LOAD;
         end
      endcase
   endfunction : settle_load

   // State asked for by a firmware mode write
   function automatic pmc_pkg::pmc_state_t req_state(
      input pmc_pkg::pmc_mode_t m,
      input pmc_pkg::pmc_state_t s);
      case (m)
         pmc_pkg::MODE_ACTIVE:
         begin
            req_state = pmc_pkg::ST_ACTIVE;
         end
         pmc_pkg::MODE_ALT_ACTIVE:
         begin
            req_state = pmc_pkg::ST_ALT_ACTIVE;
         end
         pmc_pkg::MODE_SLEEP:
         begin
            req_state = pmc_pkg::ST_SLEEP;
         end
         pmc_pkg::MODE_HIBERNATE:
         begin
            req_state = pmc_pkg::ST_HIBERNATE;
         end
         default:
         begin
            req_state = s;
         end
      endcase
   endfunction : req_state

   // Reset sources count as wakeups
   assign reset_evt = external_reset_pin | watchdog_reset_source |
                      precision_supply_reset;
   assign wake_any = irq_wake | pin_wake | reset_evt;
   // Hibernate listens to the pin interrupt and the reset sources only
   assign wake_hib = pin_wake | reset_evt;

   always_comb
   begin
      next_r = r;
      tmr_start = 1'b0;

      // Force drops once firmware sets the CPU template bit again
      if (tmpl_active[pmc_pkg::CPU_BIT])
      begin
         next_r.cpu_force = 1'b0;
      end

      case (r.st)
         pmc_pkg::ST_ACTIVE,
         pmc_pkg::ST_ALT_ACTIVE:
         begin
            if (wake_any)
            begin
               next_r = woken(next_r);
            end
            else if (mode_req_valid)
            begin
               next_r.st = req_state(mode_req, r.st);
            end
         end
         pmc_pkg::ST_SLEEP:
         begin
            if (wake_any)
            begin
               next_r.st = pmc_pkg::ST_WAKE_SLEEP;
               tmr_start = 1'b1;
            end
         end
         pmc_pkg::ST_HIBERNATE:
         begin
            if (wake_hib)
            begin
               next_r.st = pmc_pkg::ST_WAKE_HIB;
               tmr_start = 1'b1;
            end
         end
         pmc_pkg::ST_WAKE_SLEEP,
         pmc_pkg::ST_WAKE_HIB:
         begin
            // Regulators settle before code runs again
            if (tmr_expire)
            begin
               next_r = woken(next_r);
            end
         end
         default:
         begin
            next_r.st = pmc_pkg::ST_ACTIVE;
         end
      endcase

      tmr_load = settle_load(next_r.st);
      next_r.mode = mode_of(next_r.st);

      // Clock and regulator controls follow the next state
      case (next_r.st)
         pmc_pkg::ST_ACTIVE,
         pmc_pkg::ST_ALT_ACTIVE:
         begin
            next_r.sys_clk_en = 1'b1;
            next_r.lowspeed_osc_en = 1'b1;
            next_r.dig_reg_en = ~core_reg_off;
            next_r.ana_reg_en = ~core_reg_off;
            next_r.reg_buzz = 1'b0;
            next_r.hib_reg_en = 1'b1;
            next_r.state_retain = 1'b0;
         end
         pmc_pkg::ST_SLEEP:
         begin
            next_r.sys_clk_en = 1'b0;
            next_r.lowspeed_osc_en = 1'b1;
            next_r.dig_reg_en = ~core_reg_off;
            next_r.ana_reg_en = ~core_reg_off;
            next_r.reg_buzz = ~core_reg_off;
            next_r.hib_reg_en = 1'b1;
            next_r.state_retain = 1'b1;
         end
         pmc_pkg::ST_HIBERNATE:
         begin
            next_r.sys_clk_en = 1'b0;
            next_r.lowspeed_osc_en = 1'b0;
            next_r.dig_reg_en = 1'b0;
            next_r.ana_reg_en = 1'b0;
            next_r.reg_buzz = 1'b0;
            next_r.hib_reg_en = 1'b1;
            next_r.state_retain = 1'b1;
         end
         pmc_pkg::ST_WAKE_SLEEP,
         pmc_pkg::ST_WAKE_HIB:
         begin
            // Full regulation restored, system clock held until settled
            next_r.sys_clk_en = 1'b0;
            next_r.lowspeed_osc_en = 1'b1;
            next_r.dig_reg_en = ~core_reg_off;
            next_r.ana_reg_en = ~core_reg_off;
            next_r.reg_buzz = 1'b0;
            next_r.hib_reg_en = 1'b1;
            next_r.state_retain = 1'b1;
         end
         default:
         begin
            next_r.sys_clk_en = 1'b1;
            next_r.lowspeed_osc_en = 1'b1;
            next_r.dig_reg_en = 1'b1;
            next_r.ana_reg_en = 1'b1;
            next_r.reg_buzz = 1'b0;
            next_r.hib_reg_en = 1'b1;
            next_r.state_retain = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         r <= '{st: pmc_pkg::ST_ACTIVE,
                mode: pmc_pkg::MODE_ACTIVE,
                cpu_force: 1'b1,
                sys_clk_en: 1'b1,
                lowspeed_osc_en: 1'b1,
                dig_reg_en: 1'b1,
                ana_reg_en: 1'b1,
                reg_buzz: 1'b0,
                hib_reg_en: 1'b1,
                state_retain: 1'b0};
      end
      else
      begin
         r <= next_r;
      end
   end

   // Template picked by the registered mode; gate applies it every cycle
   assign run_mode = is_run(r.st);
   assign tmpl_sel = (r.st == pmc_pkg::ST_ALT_ACTIVE) ? tmpl_alt :
                     tmpl_active;

   pmc_wake_timer u_timer
   (
      .clk(clk),
      .rst(rst),
      .start(tmr_start),
      .load(tmr_load),
      .busy(tmr_busy),
      .expire(tmr_expire)
   );

   pmc_subsys_gate u_gate
   (
      .clk(clk),
      .rst(rst),
      .tmpl(tmpl_sel),
      .all_off(~run_mode),
      .cpu_force(r.cpu_force),
      .clk_en(subsys_clk_en),
      .bias_dis(subsys_bias_dis)
   );

   assign mode = r.mode;
   assign wake_busy = tmr_busy;
   assign cpu_force = r.cpu_force;
   assign sys_clk_en = r.sys_clk_en;
   assign lowspeed_osc_en = r.lowspeed_osc_en;
   assign dig_reg_en = r.dig_reg_en;
   assign ana_reg_en = r.ana_reg_en;
   assign reg_buzz = r.reg_buzz;
   assign hib_reg_en = r.hib_reg_en;
   assign state_retain = r.state_retain;

endmodule : pmc_power_mode_controller

//--- common/pmc_pkg.sv
// Constants, types and timing for the power mode controller
// Function
// - Exactly four global modes: active, alternate active, sleep, hibernate.
// - Active mode enables each subsystem from its active template bit.
// - Disabled subsystem gets digital clocks gated and analog bias disabled.
// - Template changes apply to subsystem power at once, no mode change.
// - Alternate active mode uses its own template, e.g. CPU and flash off.
// - Sleep entry disables most resources regardless of template bits.
// - Sleep keeps low-speed timing sources running for timed and RTC wakeups.
// - Hibernate stops all clocks, retains state, wakes only on pin interrupt or reset sources.
// - CPU may disable itself; it is re-enabled at the next wakeup.
// - Any wakeup sets mode active and enables CPU despite its template bit.
// - After boot the controller starts in active mode.
// - Active entered on wakeup, reset or firmware request.
// - Sleep and hibernate entered only by firmware; all subsystems off.
// - Sleep runs digital and analog core regulators duty-cycled.
// - Hibernate disables every regulator except the hibernate regulator.
// - Core regulators on after power-up; firmware may disable them.
// - Sleep to active return takes about fifteen microseconds.
// - Hibernate to active return completes within one hundred microseconds.
// - Pin, watchdog and supply resets also act as wakeup to active.
package pmc_pkg;

   localparam int SUBSYS_N = 8;
   localparam int CPU_BIT = 0;
   localparam int FLASH_BIT = 1;

   localparam int CLK_MHZ = 100;
   localparam int SLEEP_WAKE_US = 15;
   localparam int HIB_WAKE_US = 100;
   // Longest times round down to whole cycles
   localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_US * CLK_MHZ;
   localparam int HIB_WAKE_CYC = HIB_WAKE_US * CLK_MHZ;
   localparam int TMR_W = 14;

   localparam logic [SUBSYS_N-1:0] CLK_EN_RST = 8'h00;
   localparam logic [SUBSYS_N-1:0] BIAS_DIS_RST = 8'hFF;
   localparam logic [TMR_W-1:0] TMR_RST = 14'h0000;

   typedef enum logic [1:0] {
      MODE_ACTIVE,
      MODE_ALT_ACTIVE,
      MODE_SLEEP,
      MODE_HIBERNATE
   } pmc_mode_t;

   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_ALT_ACTIVE,
      ST_SLEEP,
      ST_HIBERNATE,
      ST_WAKE_SLEEP,
      ST_WAKE_HIB
   } pmc_state_t;

endpackage : pmc_pkg

//--- hdl/pmc_wake_timer.sv
// Settle timer that holds off the return to active mode
`timescale 1ns/1ps
module pmc_wake_timer
(
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [pmc_pkg::TMR_W-1:0] load,
   output logic busy,
   output logic expire
);

   typedef struct packed {
      logic [pmc_pkg::TMR_W-1:0] cnt;
      logic run;
      logic expire;
   } pmc_tmr_t;

   pmc_tmr_t r;
   pmc_tmr_t next_r;

   always_comb
   begin
      next_r = r;
      next_r.expire = 1'b0;
      if (start)
      begin
         next_r.cnt = load;
         next_r.run = 1'b1;
      end
      else if (r.run)
      begin
         if (r.cnt <= 14'h0001)
         begin
            next_r.run = 1'b0;
            next_r.expire = 1'b1;
         end
         else
         begin
            next_r.cnt = r.cnt - 14'h0001;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         r <= '{cnt: pmc_pkg::TMR_RST, run: 1'b0, expire: 1'b0};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign busy = r.run;
   assign expire = r.expire;

endmodule : pmc_wake_timer

//--- hdl/pmc_subsys_gate.sv
// Per-subsystem clock gate and analog bias disable from a template
`timescale 1ns/1ps
module pmc_subsys_gate
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [pmc_pkg::SUBSYS_N-1:0] tmpl,
   input wire logic all_off,
   input wire logic cpu_force,
   output logic [pmc_pkg::SUBSYS_N-1:0] clk_en,
   output logic [pmc_pkg::SUBSYS_N-1:0] bias_dis
);

   typedef struct packed {
      logic [pmc_pkg::SUBSYS_N-1:0] clk_en;
      logic [pmc_pkg::SUBSYS_N-1:0] bias_dis;
   } pmc_gate_t;

   pmc_gate_t r;
   pmc_gate_t next_r;
   logic [pmc_pkg::SUBSYS_N-1:0] en;

   always_comb
   begin
      en = tmpl;
      en[pmc_pkg::CPU_BIT] = tmpl[pmc_pkg::CPU_BIT] | cpu_force;
      if (all_off)
      begin
         en = '0;
      end
      next_r.clk_en = en;
      next_r.bias_dis = ~en;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         r <= '{clk_en: pmc_pkg::CLK_EN_RST,
                bias_dis: pmc_pkg::BIAS_DIS_RST};
      end
      else
      begin
         r <= next_r;
      end
   end

   assign clk_en = r.clk_en;
   assign bias_dis = r.bias_dis;

endmodule : pmc_subsys_gate

//--- verification/pmc_chk.sv
// Port checker for the power mode controller, bound to its top
`timescale 1ns/1ps
module pmc_chk
#(
   parameter int HIB_WAKE_CYC = pmc_pkg::HIB_WAKE_CYC
)
(
   input wire logic clk,
   input wire logic rst,
   input wire pmc_pkg::pmc_mode_t mode_req,
   input wire logic mode_req_valid,
   input wire logic [pmc_pkg::SUBSYS_N-1:0] tmpl_active,
   input wire logic [pmc_pkg::SUBSYS_N-1:0] tmpl_alt,
   input wire logic core_reg_off,
   input wire logic irq_wake,
   input wire logic pin_wake,
   input wire logic external_reset_pin,
   input wire logic watchdog_reset_source,
   input wire logic precision_supply_reset,
   input wire pmc_pkg::pmc_mode_t mode,
   input wire logic wake_busy,
   input wire logic cpu_force,
   input wire logic [pmc_pkg::SUBSYS_N-1:0] subsys_clk_en,
   input wire logic [pmc_pkg::SUBSYS_N-1:0] subsys_bias_dis,
   input wire logic sys_clk_en,
   input wire logic lowspeed_osc_en,
   input wire logic dig_reg_en,
   input wire logic ana_reg_en,
   input wire logic reg_buzz,
   input wire logic hib_reg_en,
   input wire logic state_retain
);
   logic [15:0] run;
   logic wh, wk, in_act, in_alt, in_slp, in_hib;
   assign wh = pin_wake | external_reset_pin | watchdog_reset_source
      | precision_supply_reset;
   assign wk = wh | irq_wake;
   assign in_act = mode == pmc_pkg::MODE_ACTIVE;
   assign in_alt = mode == pmc_pkg::MODE_ALT_ACTIVE;
   assign in_slp = mode == pmc_pkg::MODE_SLEEP;
   assign in_hib = mode == pmc_pkg::MODE_HIBERNATE;
   // Length of the current settle run
   always_ff @(posedge clk)
   begin
      if (rst || !wake_busy)
      begin
         run <= 16'h0000;
      end
      else
      begin
         run <= run + 16'h0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_bias_inverse: assert property (
      subsys_bias_dis == ~subsys_clk_en)
      else $error("bias disable not inverse of clock enable");
   chk_sleep_entry: assert property (
      mode_req_valid && mode_req == pmc_pkg::MODE_SLEEP
      && (in_act || in_alt) && !wk |=> in_slp && !sys_clk_en)
      else $error("sleep request not taken");
   chk_sleep_clocks: assert property (
      in_slp |-> lowspeed_osc_en && !sys_clk_en)
      else $error("sleep clocks wrong");
   chk_sleep_buzz: assert property (
      $rose(in_slp) |-> reg_buzz == !$past(core_reg_off))
      else $error("regulators not duty cycled in sleep");
   chk_hib_regs: assert property (
      $rose(in_hib) |-> !dig_reg_en && !ana_reg_en && hib_reg_en
      && !sys_clk_en && !lowspeed_osc_en)
      else $error("hibernate power state wrong");
   chk_state_retain: assert property (
      in_slp || in_hib |-> state_retain)
      else $error("state not retained in low power");
   chk_lowpwr_off: assert property (
      (in_slp || in_hib) && $past(mode) == mode |-> subsys_clk_en == 8'h00)
      else $error("subsystem on in low power");
   chk_wake_start: assert property (
      !wake_busy && !$past(wake_busy) && (in_slp && $past(in_slp) && wk
      || in_hib && $past(in_hib) && wh) |=> wake_busy)
      else $error("wakeup not taken");
   chk_hib_irq: assert property (
      in_hib && $past(in_hib) && !wake_busy && !$past(wake_busy)
      && irq_wake && !wh |=> !wake_busy)
      else $error("interrupt woke hibernate");
   chk_settle_len: assert property (
      $fell(wake_busy) |-> (run == 16'h05DC || run == 16'(HIB_WAKE_CYC))
      ##1 in_act && sys_clk_en && cpu_force)
      else $error("settle length or return wrong");
   chk_run_wake: assert property (
      (in_act || in_alt) && wk |=> in_act && cpu_force)
      else $error("wakeup in run mode not handled");
   chk_act_tmpl: assert property (
      in_act && $past(in_act) && !$past(rst) |-> subsys_clk_en
      == ($past(tmpl_active) | {7'h00, $past(cpu_force)}))
      else $error("active template not applied");
   chk_alt_tmpl: assert property (
      in_alt && $past(in_alt) |-> subsys_clk_en
      == ($past(tmpl_alt) | {7'h00, $past(cpu_force)}))
      else $error("alternate template not applied");
   cov_sleep: cover property ($rose(in_slp));
   cov_hib: cover property ($rose(in_hib));
   cov_settle: cover property ($fell(wake_busy));
   cov_run_wake: cover property ((in_act || in_alt) && wk);
endmodule : pmc_chk

bind pmc_power_mode_controller pmc_chk #(.HIB_WAKE_CYC(HIB_WAKE_CYC)) chk_u (
   .clk(clk), .rst(rst), .mode_req(mode_req),
   .mode_req_valid(mode_req_valid), .tmpl_active(tmpl_active),
   .tmpl_alt(tmpl_alt), .core_reg_off(core_reg_off), .irq_wake(irq_wake),
   .pin_wake(pin_wake), .external_reset_pin(external_reset_pin),
   .watchdog_reset_source(watchdog_reset_source),
   .precision_supply_reset(precision_supply_reset), .mode(mode),
   .wake_busy(wake_busy), .cpu_force(cpu_force),
   .subsys_clk_en(subsys_clk_en), .subsys_bias_dis(subsys_bias_dis),
   .sys_clk_en(sys_clk_en), .lowspeed_osc_en(lowspeed_osc_en),
   .dig_reg_en(dig_reg_en), .ana_reg_en(ana_reg_en), .reg_buzz(reg_buzz),
   .hib_reg_en(hib_reg_en), .state_retain(state_retain));

//--- verification/pmc_fw_model.sv
// Firmware and wakeup source model driving the controller inputs
`timescale 1ns/1ps
module pmc_fw_model
(
   input wire logic clk,
   output pmc_pkg::pmc_mode_t mode_req,
   output logic mode_req_valid,
   output logic [pmc_pkg::SUBSYS_N-1:0] tmpl_active,
   output logic [pmc_pkg::SUBSYS_N-1:0] tmpl_alt,
   output logic core_reg_off,
   output logic [4:0] wake
);
   initial
   begin
      mode_req = pmc_pkg::MODE_HIBERNATE;
      mode_req_valid = 1'b0;
      tmpl_active = 8'h00;
      tmpl_alt = 8'h00;
      core_reg_off = 1'b0;
      wake = 5'h00;
   end
   // One-cycle mode write, value scrambled once released
   task automatic req(input pmc_pkg::pmc_mode_t m);
      @(negedge clk);
      mode_req = m;
      mode_req_valid = 1'b1;
      @(negedge clk);
      mode_req_valid = 1'b0;
      mode_req = pmc_pkg::pmc_mode_t'(~m);
   endtask : req
   // Templates and regulator switch change at any time
   task automatic set(input logic [7:0] act, input logic [7:0] alt,
      input logic off);
      @(negedge clk);
      tmpl_active = act;
      tmpl_alt = alt;
      core_reg_off = off;
   endtask : set
   task automatic pulse(input int src);
      @(negedge clk);
      wake[src] = 1'b1;
      @(negedge clk);
      wake = 5'h00;
   endtask : pulse
endmodule : pmc_fw_model

//--- verification/pmc_power_mode_controller_tb_top.sv
// Self-checking testbench for the power mode controller
`timescale 1ns/1ps
module pmc_power_mode_controller_tb_top;
   localparam int HIB_CYC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   pmc_pkg::pmc_mode_t mode_req, mode;
   logic mode_req_valid, core_reg_off, wake_busy, cpu_force;
   logic [7:0] tmpl_active, tmpl_alt, subsys_clk_en, subsys_bias_dis;
   logic [4:0] wake;
   logic sys_clk_en, lowspeed_osc_en, dig_reg_en, ana_reg_en, reg_buzz;
   logic hib_reg_en, state_retain;
   int error_cnt = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   pmc_fw_model fw_u (.clk(clk), .mode_req(mode_req),
      .mode_req_valid(mode_req_valid), .tmpl_active(tmpl_active),
      .tmpl_alt(tmpl_alt), .core_reg_off(core_reg_off), .wake(wake));
   pmc_power_mode_controller #(.HIB_WAKE_CYC(HIB_CYC)) dut_u (
      .clk(clk), .rst(rst), .mode_req(mode_req),
      .mode_req_valid(mode_req_valid), .tmpl_active(tmpl_active),
      .tmpl_alt(tmpl_alt), .core_reg_off(core_reg_off),
      .irq_wake(wake[0]), .pin_wake(wake[1]),
      .external_reset_pin(wake[2]), .watchdog_reset_source(wake[3]),
      .precision_supply_reset(wake[4]), .mode(mode),
      .wake_busy(wake_busy), .cpu_force(cpu_force),
      .subsys_clk_en(subsys_clk_en), .subsys_bias_dis(subsys_bias_dis),
      .sys_clk_en(sys_clk_en), .lowspeed_osc_en(lowspeed_osc_en),
      .dig_reg_en(dig_reg_en), .ana_reg_en(ana_reg_en),
      .reg_buzz(reg_buzz), .hib_reg_en(hib_reg_en),
      .state_retain(state_retain));
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   function automatic logic [15:0] pwr();
      return {9'h000, sys_clk_en, lowspeed_osc_en, dig_reg_en, ana_reg_en,
         reg_buzz, hib_reg_en, state_retain};
   endfunction : pwr
   task automatic stop_test;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
      begin
         $display("bench passed");
      end
      else
      begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   task automatic t_reset;
      check("reset mode", 16'h0000, 16'(mode));
      check("reset power", 16'h007A, pwr());
      check("reset subsys", 16'h00FF, {subsys_clk_en, subsys_bias_dis});
   endtask : t_reset
   task automatic t_tmpl;
      fw_u.set(8'h0A, 8'h30, 1'b0);
      @(negedge clk);
      check("forced cpu", 16'h000B, 16'(subsys_clk_en));
      fw_u.set(8'h0D, 8'h30, 1'b0);
      @(negedge clk);
      check("cpu_force", 16'h0000, 16'(cpu_force));
      fw_u.set(8'h0C, 8'h30, 1'b0);
      @(negedge clk);
      check("subsys", 16'h0CF3, {subsys_clk_en, subsys_bias_dis});
   endtask : t_tmpl
   task automatic t_alt;
      fw_u.req(pmc_pkg::MODE_ALT_ACTIVE);
      @(negedge clk);
      check("alt subsys", 16'h30CF, {subsys_clk_en, subsys_bias_dis});
      fw_u.set(8'h0C, 8'h30, 1'b1);
      @(negedge clk);
      check("core regs", 16'h0000, 16'({dig_reg_en, ana_reg_en}));
      fw_u.set(8'h0C, 8'h30, 1'b0);
      fw_u.req(pmc_pkg::MODE_ACTIVE);
      check("fw active", 16'h0000, 16'(mode));
   endtask : t_alt
   task automatic t_run_wake;
      fw_u.set(8'h0D, 8'h30, 1'b0);
      fw_u.req(pmc_pkg::MODE_ALT_ACTIVE);
      fw_u.set(8'h0C, 8'h30, 1'b0);
      fw_u.pulse(3);
      check("run wake mode", 16'h0000, 16'(mode));
      check("run wake cpu", 16'h0001, 16'(cpu_force));
      @(negedge clk);
      check("run wake subsys", 16'h000D, 16'(subsys_clk_en));
   endtask : t_run_wake
   task automatic t_low(input pmc_pkg::pmc_mode_t m, input int src,
      input int n_exp);
      int n;
      fw_u.req(m);
      check("low mode", 16'(m), 16'(mode));
      check("low power", (m == pmc_pkg::MODE_SLEEP) ? 16'h003F : 16'h0003,
         pwr());
      @(negedge clk);
      check("low subsys", 16'h00FF, {subsys_clk_en, subsys_bias_dis});
      fw_u.req(pmc_pkg::MODE_ACTIVE);
      check("ignored req", 16'(m), 16'(mode));
      if (m == pmc_pkg::MODE_HIBERNATE)
      begin
         fw_u.pulse(0);
         check("irq in hib", 16'h0000, 16'(wake_busy));
      end
      fw_u.pulse(src);
      check("settling", 16'h0001, 16'(wake_busy));
      n = 1;
      while (mode !== pmc_pkg::MODE_ACTIVE && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      check("wake cycles", 16'(n_exp), 16'(n));
      @(negedge clk);
      check("woken", 16'h010D, {7'h00, cpu_force, subsys_clk_en});
   endtask : t_low
   initial
   begin
      repeat (5) @(negedge clk);
      t_reset();
      rst = 1'b0;
      t_tmpl();
      t_alt();
      t_run_wake();
      for (int s = 0; s < 5; s++)
      begin
         t_low(pmc_pkg::MODE_SLEEP, s, 1502);
      end
      for (int s = 1; s < 5; s++)
      begin
         t_low(pmc_pkg::MODE_HIBERNATE, s, HIB_CYC + 2);
      end
      stop_test();
   end
   // About two and a half times the expected run
   initial
   begin
      #200000;
      error_cnt++;
      stop_test();
   end
endmodule : pmc_power_mode_controller_tb_top
